// file: ppw_pkg.sv
// package for the parallel port write register block
// assumes an APB slave with 32-bit data, registers on aligned words
package ppw_pkg;
    // printed register indices; byte address is four times the index
    localparam logic [2:0] IDX_HS_SET = 3'h0;
    localparam logic [2:0] IDX_IF_RESET = 3'h1;
    localparam logic [2:0] IDX_EXT_MASK = 3'h2;
    localparam logic [2:0] IDX_IRQ_DMA = 3'h3;
    localparam logic [2:0] IDX_OUT_HIGH = 3'h4;
    localparam logic [2:0] IDX_OUT_LOW = 3'h5;
    localparam logic [2:0] IDX_UNDEF = 3'h6;
    localparam logic [2:0] IDX_CTL_DRIVE = 3'h7;
    // extra registers outside the printed map
    localparam logic [3:0] IDX_EVT_STATUS = 4'h8;
    localparam logic [3:0] IDX_EVT_MASK = 4'h9;
    localparam logic [3:0] IDX_PERIPH = 4'ha;
    localparam int ADDR_W = 6;
    localparam int IDX_LSB = 2;
    // field positions
    localparam int EXT_EN_BIT = 0;
    localparam int GIE_BIT = 7;
    localparam int IRQ_REQ_BIT = 6;
    localparam int DMA_LSB = 0;
    localparam int DMA_MSB = 3;
    localparam int LVL_LSB = 4;
    localparam int CONTROL_OUT_ONE_BIT = 5;
    localparam int CONTROL_OUT_ZERO_BIT = 4;
    // event bits
    localparam int EV_READY = 0;
    localparam int EV_EXT = 1;
    localparam int EV_W = 2;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [EV_W-1:0] EV_RST = 2'h0;
    typedef struct packed {
        logic [7:0] ext_mask;
        logic [7:0] irq_dma;
        logic [15:0] out_word;
        logic [7:0] ctl_drive;
    } ppw_regs_t;
endpackage : ppw_pkg

// file: ppw_apb_dec.sv
// apb address decode and write/read strobes for the write register block
// assumes apb master timing; slave answers with zero wait states
module ppw_apb_dec (
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ppw_pkg::ADDR_W-1:0] paddr,
    output logic wr_en,
    output logic rd_en,
    output logic [3:0] idx,
    output logic mapped
);
    assign idx = paddr[ppw_pkg::ADDR_W-1:ppw_pkg::IDX_LSB];
    // indices 0..10 are mapped; others answer slverr
    assign mapped = (idx <= ppw_pkg::IDX_PERIPH);
    assign wr_en = psel & penable & pwrite & mapped;
    assign rd_en = psel & penable & ~pwrite & mapped;
endmodule : ppw_apb_dec

// file: ppw_top.sv
// parallel port write registers behind an apb slave
// assumes peripheral lines synchronous to clock; one clock domain
// Operation
// (R1) write reg 0 sets handshake request line
// (R2) write reg 1 resets whole interface
// (R3) reg 2 bit 0 enables external interrupt
// (R4) reg 3 bit 7 global interrupt enable
// (R5) reg 3 bits 3..0 control dma
// (R6) reg 4 loads output bits 15..8
// (R7) reg 5 loads output bits 7..0
// (R8) reg 6 writes have no effect
// (R9) reg 7 bits 5,4 drive controls inverted
// (R10) read reg 0 shows interface ready
// (R11) read reg 3 shows irq, dma state
// (R12) host writes high byte before low
module ppw_top (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ppw_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic peripheral_flag,
    input wire logic external_interrupt_line,
    input wire logic [1:0] level_switches,
    output logic handshake_request_line,
    output logic [15:0] out_word,
    output logic control_out_zero,
    output logic control_out_one,
    output logic [3:0] dma_enable,
    output logic card_irq,
    output logic irq
);
    ppw_pkg::ppw_regs_t regs_reg, regs_next;
    logic hs_reg, hs_next;
    logic [ppw_pkg::EV_W-1:0] ev_stat_reg, ev_stat_next;
    logic [ppw_pkg::EV_W-1:0] ev_mask_reg, ev_mask_next;
    logic ready_q_reg;
    logic [31:0] rdata_reg, rdata_next;
    logic wr_en, rd_en, mapped;
    logic [3:0] idx;
    logic [7:0] wbyte;

    ppw_apb_dec u_dec (
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .wr_en(wr_en),
        .rd_en(rd_en),
        .idx(idx),
        .mapped(mapped)
    );

    function automatic logic hit(input logic [3:0] i, input logic [2:0] r);
        hit = (i == {1'b0, r});
    endfunction : hit

    assign wbyte = pwdata[7:0];
    assign pready = psel & penable;
    assign pslverr = psel & penable & ~mapped;

    // (R1) any data sets line
    wire wr_hs = wr_en & hit(idx, ppw_pkg::IDX_HS_SET);
    // (R2) data ignored, full reset
    wire wr_rst = wr_en & hit(idx, ppw_pkg::IDX_IF_RESET);
    wire wr_mask = wr_en & hit(idx, ppw_pkg::IDX_EXT_MASK);
    wire wr_idma = wr_en & hit(idx, ppw_pkg::IDX_IRQ_DMA);
    wire wr_hi = wr_en & hit(idx, ppw_pkg::IDX_OUT_HIGH);
    wire wr_lo = wr_en & hit(idx, ppw_pkg::IDX_OUT_LOW);
    wire wr_ctl = wr_en & hit(idx, ppw_pkg::IDX_CTL_DRIVE);
    wire wr_est = wr_en & (idx == ppw_pkg::IDX_EVT_STATUS);
    wire wr_emk = wr_en & (idx == ppw_pkg::IDX_EVT_MASK);
    // ready: peripheral idle and no request outstanding
    wire if_ready = ~hs_reg & ~peripheral_flag;
    // (R3) external line gated by its enable
    wire ext_req = external_interrupt_line
        & regs_reg.ext_mask[ppw_pkg::EXT_EN_BIT];
    // (R4) global enable gates card request
    assign card_irq = ext_req & regs_reg.irq_dma[ppw_pkg::GIE_BIT];
    wire ready_rise = if_ready & ~ready_q_reg;

    always_comb begin
        regs_next = regs_reg;
        // (R3) only bit 0 kept
        if (wr_mask)
            regs_next.ext_mask = {7'h00, wbyte[ppw_pkg::EXT_EN_BIT]};
        // (R4) bit 7 kept, 6..4 unused
        // (R5) dma bits 3..0 kept
        if (wr_idma)
            regs_next.irq_dma = {wbyte[ppw_pkg::GIE_BIT], 3'h0,
                wbyte[ppw_pkg::DMA_MSB:ppw_pkg::DMA_LSB]};
        // (R6) upper output byte
        if (wr_hi)
            regs_next.out_word[15:8] = wbyte;
        // (R7) lower output byte
        if (wr_lo)
            regs_next.out_word[7:0] = wbyte;
        // (R9) only bits 5 and 4 kept
        if (wr_ctl)
            regs_next.ctl_drive = {2'h0, wbyte[ppw_pkg::CONTROL_OUT_ONE_BIT],
                wbyte[ppw_pkg::CONTROL_OUT_ZERO_BIT], 4'h0};
        // (R8) undefined slot stores nothing
    end

    // (R1) set by strobe, cleared by peripheral answer
    assign hs_next = wr_hs | (hs_reg & ~peripheral_flag);

    // set wins over write-one-to-clear
    always_comb begin
        ev_stat_next = ev_stat_reg;
        if (wr_est)
            ev_stat_next = ev_stat_reg & ~pwdata[ppw_pkg::EV_W-1:0];
        if (ready_rise)
            ev_stat_next[ppw_pkg::EV_READY] = 1'b1;
        if (card_irq)
            ev_stat_next[ppw_pkg::EV_EXT] = 1'b1;
    end
    assign ev_mask_next = wr_emk ? pwdata[ppw_pkg::EV_W-1:0] : ev_mask_reg;

    always_comb begin
        rdata_next = 32'h0;
        unique case (idx)
            // (R10) ready flag
            {1'b0, ppw_pkg::IDX_HS_SET}: rdata_next = {31'h0, if_ready};
            // (R11) irq/dma status byte
            {1'b0, ppw_pkg::IDX_IRQ_DMA}: rdata_next = {24'h0,
                regs_reg.irq_dma[ppw_pkg::GIE_BIT],
                card_irq, level_switches,
                regs_reg.irq_dma[ppw_pkg::DMA_MSB:ppw_pkg::DMA_LSB]};
            ppw_pkg::IDX_EVT_STATUS: rdata_next = {30'h0, ev_stat_reg};
            ppw_pkg::IDX_EVT_MASK: rdata_next = {30'h0, ev_mask_reg};
            ppw_pkg::IDX_PERIPH: rdata_next = {30'h0, handshake_request_line,
                peripheral_flag};
            default: rdata_next = 32'h0;
        endcase
    end
    assign prdata = rdata_reg;

    always_ff @(posedge clock) begin
        // (R2) reset strobe acts like rst_n
        if (!rst_n || wr_rst) begin
            regs_reg <= '0;
            hs_reg <= 1'b0;
            ev_stat_reg <= ppw_pkg::EV_RST;
            ev_mask_reg <= ppw_pkg::EV_RST;
            ready_q_reg <= 1'b0;
        end else begin
            regs_reg <= regs_next;
            hs_reg <= hs_next;
            ev_stat_reg <= ev_stat_next;
            ev_mask_reg <= ev_mask_next;
            ready_q_reg <= if_ready;
        end
    end

    // read data registered at setup so it is valid in the access phase
    always_ff @(posedge clock) begin
        if (!rst_n)
            rdata_reg <= 32'h0;
        else if (psel & ~penable)
            rdata_reg <= rdata_next;
    end

    assign handshake_request_line = hs_reg;
    assign out_word = regs_reg.out_word;
    // (R9) one drives low
    assign control_out_one = ~regs_reg.ctl_drive[ppw_pkg::CONTROL_OUT_ONE_BIT];
    assign control_out_zero = ~regs_reg.ctl_drive[ppw_pkg::CONTROL_OUT_ZERO_BIT];
    // (R5) dma enables out
    assign dma_enable = regs_reg.irq_dma[ppw_pkg::DMA_MSB:ppw_pkg::DMA_LSB];
    assign irq = |(ev_stat_reg & ev_mask_reg);
endmodule : ppw_top

// file: ppw_checker.sv
// assertions on the write register block's apb and pin side
// assumes zero-wait apb and register index = byte address / 4
module ppw_checker (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ppw_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic handshake_request_line,
    input wire logic [15:0] out_word,
    input wire logic control_out_zero,
    input wire logic control_out_one,
    input wire logic [3:0] dma_enable,
    input wire logic card_irq
);
    timeunit 1ns / 1ps;
    wire logic wr = psel && penable && pwrite;
    wire logic [3:0] ix = paddr[5:2];
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    property p_hs;
        wr && ix == 4'h0 |=> handshake_request_line; endproperty
    a_hs: assert property (p_hs) else $error("handshake not set");
    property p_rst;
        wr && ix == 4'h1 |=> out_word == 16'h0 && dma_enable == 4'h0
            && control_out_one && control_out_zero; endproperty
    a_rst: assert property (p_rst) else $error("reset write missed");
    property p_msk;
        wr && ix == 4'h2 && !pwdata[0] |=> !card_irq; endproperty
    a_msk: assert property (p_msk) else $error("mask ignored");
    property p_gie;
        wr && ix == 4'h3 && !pwdata[7] |=> !card_irq; endproperty
    a_gie: assert property (p_gie) else $error("global enable ignored");
    property p_dma;
        wr && ix == 4'h3 |=> dma_enable == $past(pwdata[3:0]); endproperty
    a_dma: assert property (p_dma) else $error("dma bits wrong");
    property p_hi;
        wr && ix == 4'h4 |=> out_word[15:8] == $past(pwdata[7:0]);
    endproperty
    a_hi: assert property (p_hi) else $error("high byte wrong");
    property p_lo;
        wr && ix == 4'h5 |=> out_word[7:0] == $past(pwdata[7:0]);
    endproperty
    a_lo: assert property (p_lo) else $error("low byte wrong");
    property p_ctl;
        wr && ix == 4'h7 |=> {control_out_one, control_out_zero}
            == ~$past(pwdata[5:4]); endproperty
    a_ctl: assert property (p_ctl) else $error("control lines wrong");
endmodule : ppw_checker

bind ppw_top ppw_checker i_ppw_checker (.*);

// file: ppw_periph.sv
// peripheral model answering the handshake request line
// assumes it runs on the block's own clock
module ppw_periph (
    input wire logic clock,
    input wire logic handshake_request_line,
    input wire logic [3:0] lat,
    output logic peripheral_flag = 1'b0
);
    timeunit 1ns / 1ps;
    logic [3:0] wait_reg = 4'h0;
    // one-cycle acknowledge after lat cycles, lat 0 is prompt
    always @(posedge clock) begin
        wait_reg <= handshake_request_line ? wait_reg + 4'h1 : 4'h0;
        peripheral_flag <= handshake_request_line && wait_reg == lat;
    end
endmodule : ppw_periph

// file: test_ppw_top.sv
// self-checking bench for the parallel port write registers
// assumes zero-wait apb slave, peripheral model on the handshake
module test_ppw_top;
    timeunit 1ns / 1ps;
    logic clock = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, external_interrupt_line = 1'b0, serr;
    logic [5:0] paddr = 6'h0;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic pready, pslverr, peripheral_flag, handshake_request_line;
    logic control_out_zero, control_out_one, card_irq, irq;
    logic [15:0] out_word;
    logic [3:0] dma_enable, lat = 4'h5;
    logic [1:0] level_switches = 2'h2;
    int err_total = 0, n_compared = 0;
    always #20 clock = ~clock;
    ppw_top i_ppw_top (.*);
    ppw_periph i_ppw_periph (.*);
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic xfer(input logic we, input logic [3:0] ix,
        input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= we;
        paddr <= {ix, 2'h0};
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rdat = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask : xfer
    task automatic rd(input string nm, input logic [3:0] ix,
        input logic [31:0] e);
        xfer(1'b0, ix, 32'h0);
        chk(nm, e, rdat);
    endtask : rd
    task automatic tally_and_finish;
        $display("errors %0d compares %0d", err_total, n_compared);
        if (err_total == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (3000) @(posedge clock);
        err_total++;
        tally_and_finish();
    end
    initial begin
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        rd("ready", 4'h0, 32'h1);
        for (int k = 0; k < 2; k++) begin
            lat <= k ? 4'h0 : 4'h5;
            xfer(1'b1, 4'h0, 32'hff);
            chk("hs", 32'h1, {31'h0, handshake_request_line});
            if (k == 0) begin
                rd("busy", 4'h0, 32'h0);
                rd("periph", 4'ha, 32'h2);
            end
            for (int n = 0; n < 20 && handshake_request_line; n++)
                @(posedge clock);
            rd("ready2", 4'h0, 32'h1);
        end
        external_interrupt_line <= 1'b1;
        xfer(1'b1, 4'h3, 32'h8f);
        xfer(1'b1, 4'h2, 32'h1);
        chk("card_irq", 32'h1, {31'h0, card_irq});
        rd("irq_stat", 4'h3, 32'hef);
        xfer(1'b1, 4'h9, 32'h2);
        chk("irq", 32'h1, {31'h0, irq});
        xfer(1'b1, 4'h3, 32'h0f);
        chk("gie_off", 32'h0, {31'h0, card_irq});
        xfer(1'b1, 4'h8, 32'h2);
        chk("irq_clr", 32'h0, {31'h0, irq});
        xfer(1'b1, 4'h3, 32'h8f);
        xfer(1'b1, 4'h2, 32'hfe);
        chk("mask_off", 32'h0, {31'h0, card_irq});
        for (int i = 0; i < 4; i++) begin
            xfer(1'b1, 4'h3, 32'h1 << i);
            chk("dma", 32'h1 << i, {28'h0, dma_enable});
        end
        level_switches <= 2'h1;
        rd("lvl_stat", 4'h3, 32'h18);
        rd("ev_mask", 4'h9, 32'h2);
        xfer(1'b1, 4'h4, 32'hffffffa5);
        xfer(1'b1, 4'h5, 32'h1234563c);
        chk("out_word", 32'ha53c, {16'h0, out_word});
        xfer(1'b1, 4'h6, 32'hffffffff);
        chk("undef", 32'ha53c, {16'h0, out_word});
        rd("undef_rd", 4'h6, 32'h0);
        xfer(1'b1, 4'hf, 32'h0);
        chk("slverr", 32'h1, {31'h0, serr});
        for (int v = 0; v < 4; v++) begin
            xfer(1'b1, 4'h7, 32'hcf | (v << 4));
            chk("ctl", ~v & 3, {control_out_one, control_out_zero});
        end
        xfer(1'b1, 4'h1, 32'h5a);
        chk("reset", 32'hc00000, {control_out_one, control_out_zero,
            out_word, dma_enable, handshake_request_line, card_irq});
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        rd("ready_rst", 4'h0, 32'h1);
        chk("irq_rst", 32'h0, {31'h0, irq});
        tally_and_finish();
    end
endmodule : test_ppw_top
